// *** drm_ctrl.sv ***
// disc/drum controller: programmed channel instruction interpreter
// assumes one instruction strobe per cycle, synchronous drive signals
//
// Summary of operation
// - upper five address bits match; low three mode
// - six legal control-out modes, others refused
// - low fifteen bits sector, top bit unit
// - sector 64 words, large drums 128
// - read/write control-out acked only when idle
// - interrupt-only control-out acked even when busy
// - no control-out ack without heads actuated
// - write allow raises request after ack
// - read allow raises request when word ready
// - accepted control-out drops service request
// - transfer runs until CPU misses holding time
// - data/status instructions ignore low three bits
// - data-out acked only when buffer free
// - write request when buffer empty, drop on ack
// - timing error keeps request, ends command
// - words written sequentially with odd parity
// - word and sector advance automatically
// - data-in returns last word, else zero
// - data-in acked only with word; request then
// - acked data-in drops service request
// - sequential read, parity error terminates
// - status bits busy, ready, errors, sync, address
// - status-in never acked, drops request
// - address-in answers own address if granted
// - address-in answer drops service request
`timescale 1ns/10ps
`include "drm_defines.svh"
module drm_ctrl #(
  parameter logic [4:0]  DEV_ADDR   = 5'h10,
  parameter logic [14:0] MAX_SECTOR = 15'h7FFF
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire drm_pkg::drm_instr_t instr,
  input  wire drm_pkg::drm_strb_t  strb,
  input  wire logic               prio_in,
  input  wire logic               heads_on,
  input  wire logic               dev_ready,
  input  wire logic               large_sec,
  input  wire logic               wr_locked,
  input  wire logic               sync_lost,
  input  wire logic               drv_on_sector,
  input  wire logic               drv_tick,
  input  wire logic [16:0]        drv_rd_word,
  output logic                    ack_ff,
  output logic                    svc_ff,
  output logic [15:0]             data_ff,
  output logic                    drv_start_ff,
  output logic                    drv_unit_ff,
  output logic [14:0]             drv_sector_ff,
  output logic [6:0]              drv_word_ff,
  output logic [16:0]             drv_wr_ff,
  output logic                    drv_wr_en_ff
);
  import drm_pkg::*;

  drm_state_t  state_ff;
  logic        wr_ff;
  logic        intr_en_ff;
  logic [15:0] wbuf_ff;
  logic        wbuf_full_ff;
  logic [15:0] rbuf_ff;
  logic        rbuf_full_ff;
  logic        need_ff;
  logic        perr_ff;
  logic        wlock_ff;
  logic        term_ff;
  logic        sync_ff;
  logic        ill_ff;
  logic        hit;
  logic [2:0]  mode;
  logic        legal;
  logic        xfer_cmd;
  logic        busy;
  logic        co_ok;
  logic        co_go;
  logic        do_ok;
  logic        di_ok;
  logic        si_hit;
  logic        ai_ok;
  logic        need_now;
  logic        svc_set;
  logic        svc_clr;
  logic        tick_x;
  logic        end_sec;
  logic        rd_bad;
  logic        wr_miss;
  logic        rd_miss;
  logic [15:0] status;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a[7:3] == DEV_ADDR);
  endfunction

  function automatic logic mode_legal(input logic [2:0] m);
    mode_legal = (m != `DRM_MODE_X1) && (m != `DRM_MODE_X2);
  endfunction

  assign hit      = addr_hit(instr.addr);
  assign mode     = instr.addr[2:0];
  assign legal    = mode_legal(mode);
  assign xfer_cmd = mode[`DRM_MB_RD] | mode[`DRM_MB_WR];
  assign busy     = (state_ff != DRM_IDLE);
  assign co_ok    = strb.co && hit && legal && heads_on
                    && (!xfer_cmd || !busy);
  assign co_go    = co_ok && xfer_cmd;
  assign do_ok    = strb.dout && hit && busy && wr_ff
                    && !wbuf_full_ff && !tick_x;
  assign di_ok    = strb.di && hit && rbuf_full_ff;
  assign si_hit   = strb.si && hit;
  assign ai_ok    = strb.ai && svc_ff && prio_in;
  assign tick_x   = drv_tick && (state_ff == DRM_XFER);
  assign end_sec  = large_sec ? (drv_word_ff == `DRM_SEC_LARGE)
                              : (drv_word_ff == `DRM_SEC_SMALL);
  assign rd_bad   = !(^drv_rd_word);
  assign wr_miss  = tick_x && wr_ff && !wbuf_full_ff;
  assign rd_miss  = tick_x && !wr_ff && rbuf_full_ff;

  always_comb
  begin
    status = `DRM_ZERO16;
    status[`DRM_ST_BUSY]  = busy;
    status[`DRM_ST_NRDY]  = !dev_ready;
    status[`DRM_ST_PERR]  = perr_ff;
    status[`DRM_ST_WLOCK] = wlock_ff;
    status[`DRM_ST_TERM]  = term_ff;
    status[`DRM_ST_SYNC]  = sync_ff;
    status[`DRM_ST_ILL]   = ill_ff;
  end

  // command sequencing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff     <= DRM_IDLE;
      wr_ff        <= 1'b0;
      drv_start_ff <= 1'b0;
      drv_unit_ff  <= 1'b0;
      drv_sector_ff <= 15'h0000;
      drv_word_ff  <= 7'h00;
    end
    else
    begin
      drv_start_ff <= 1'b0;
      unique case (state_ff)
        DRM_IDLE:
        begin
          if (co_go && (instr.acc[14:0] <= MAX_SECTOR)
              && !(mode[`DRM_MB_WR] && wr_locked))
          begin
            state_ff      <= DRM_SEEK;
            wr_ff         <= mode[`DRM_MB_WR];
            drv_unit_ff   <= instr.acc[15];
            drv_sector_ff <= instr.acc[14:0];
            drv_word_ff   <= 7'h00;
            drv_start_ff  <= 1'b1;
          end
        end
        DRM_SEEK:
        begin
          if (sync_lost)
            state_ff <= DRM_IDLE;
          else if (drv_on_sector)
            state_ff <= DRM_XFER;
        end
        DRM_XFER:
        begin
          if (sync_lost || wr_miss || rd_miss)
            state_ff <= DRM_IDLE;
          else if (tick_x && !wr_ff && rd_bad)
            state_ff <= DRM_IDLE;
          else if (tick_x)
          begin
            if (end_sec)
            begin
              drv_word_ff   <= 7'h00;
              drv_sector_ff <= drv_sector_ff + 15'h0001;
            end
            else
              drv_word_ff <= drv_word_ff + 7'h01;
          end
        end
      endcase
    end
  end

  // write buffer and recording
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wbuf_ff      <= `DRM_ZERO16;
      wbuf_full_ff <= 1'b0;
      drv_wr_ff    <= 17'h00000;
      drv_wr_en_ff <= 1'b0;
    end
    else
    begin
      drv_wr_en_ff <= 1'b0;
      if (co_go && !busy)
        wbuf_full_ff <= 1'b0;
      else if (do_ok)
      begin
        wbuf_ff      <= instr.acc;
        wbuf_full_ff <= 1'b1;
      end
      else if (tick_x && wr_ff && wbuf_full_ff && !sync_lost)
      begin
        drv_wr_ff    <= {~(^wbuf_ff), wbuf_ff};
        drv_wr_en_ff <= 1'b1;
        wbuf_full_ff <= 1'b0;
      end
    end
  end

  // read buffer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rbuf_ff      <= `DRM_ZERO16;
      rbuf_full_ff <= 1'b0;
    end
    else
    begin
      if (co_go && !busy)
        rbuf_full_ff <= 1'b0;
      else if (di_ok)
        rbuf_full_ff <= 1'b0;
      else if (tick_x && !wr_ff && !rbuf_full_ff && !rd_bad
               && !sync_lost)
      begin
        rbuf_ff      <= drv_rd_word[15:0];
        rbuf_full_ff <= 1'b1;
      end
    end
  end

  // error status
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      perr_ff  <= 1'b0;
      wlock_ff <= 1'b0;
      term_ff  <= 1'b0;
      sync_ff  <= 1'b0;
      ill_ff   <= 1'b0;
    end
    else if (co_go && !busy)
    begin
      perr_ff  <= 1'b0;
      term_ff  <= 1'b0;
      sync_ff  <= 1'b0;
      wlock_ff <= mode[`DRM_MB_WR] && wr_locked;
      ill_ff   <= (instr.acc[14:0] > MAX_SECTOR);
    end
    else
    begin
      if (tick_x && !wr_ff && !rbuf_full_ff && rd_bad)
        perr_ff <= 1'b1;
      if (wr_miss || rd_miss || (tick_x && !wr_ff && rd_bad))
        term_ff <= 1'b1;
      if (busy && sync_lost)
        sync_ff <= 1'b1;
    end
  end

  // interrupt mode and service request
  assign need_now = busy && wr_ff && !wbuf_full_ff
                    || rbuf_full_ff;
  assign svc_set  = intr_en_ff && need_now && !need_ff;
  assign svc_clr  = co_ok || do_ok || di_ok
                    || si_hit || ai_ok;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intr_en_ff <= 1'b0;
      need_ff    <= 1'b0;
      svc_ff     <= 1'b0;
    end
    else
    begin
      need_ff <= intr_en_ff && need_now && !co_go;
      if (co_ok)
        intr_en_ff <= !mode[`DRM_MB_INH];
      if (svc_set)
        svc_ff <= 1'b1;
      else if (svc_clr)
        svc_ff <= 1'b0;
    end
  end

  // acknowledge and data lines
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff  <= 1'b0;
      data_ff <= `DRM_ZERO16;
    end
    else
    begin
      ack_ff <= co_ok || do_ok || di_ok;
      if (di_ok)
        data_ff <= rbuf_ff;
      else if (si_hit)
        data_ff <= status;
      else if (ai_ok)
        data_ff <= {8'h00, DEV_ADDR, 3'h0};
      else
        data_ff <= `DRM_ZERO16;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_allow;
    co_ok && !busy && mode == `DRM_MODE_AW && !wr_locked
    && instr.acc[14:0] <= MAX_SECTOR;
  endsequence

  sequence s_ack_then_svc;
    ##1 ack_ff ##[0:2] svc_ff;
  endsequence

  AST_XFER_BUSY: assert property (
    strb.co && xfer_cmd && busy |=> !ack_ff)
    else $error("read/write control-out acked while busy");
  AST_INT_ONLY: assert property (
    strb.co && hit && legal && !xfer_cmd && heads_on |=> ack_ff)
    else $error("interrupt-only control-out not acked");
  AST_HEADS: assert property (
    strb.co && !heads_on && !strb.dout && !strb.di |=> !ack_ff)
    else $error("control-out acked without heads");
  AST_WR_SVC: assert property (
    s_wr_allow |-> s_ack_then_svc)
    else $error("no request after write command");
  AST_SI_NOACK: assert property (
    strb.si && !strb.co && !strb.dout && !strb.di
    |=> !ack_ff)
    else $error("status-in was acked");
  AST_SI_DROP: assert property (
    si_hit && !svc_set |=> !svc_ff)
    else $error("status-in did not drop request");
  AST_DI_ZERO: assert property (
    strb.di && !di_ok && !strb.si && !strb.ai
    |=> data_ff == `DRM_ZERO16)
    else $error("unacked data-in returned nonzero");
  AST_ODD_PAR: assert property (
    drv_wr_en_ff |-> ^drv_wr_ff)
    else $error("recorded word not odd parity");
  AST_PERR: assert property (
    tick_x && !wr_ff && !rbuf_full_ff && rd_bad && !sync_lost
    |=> state_ff == DRM_IDLE && perr_ff)
    else $error("parity error did not terminate read");
  AST_AI_ADDR: assert property (
    ai_ok && !strb.si && !strb.di && !strb.co && !strb.dout && !svc_set
    |=> data_ff == {8'h00, DEV_ADDR, 3'h0} && !svc_ff && !ack_ff)
    else $error("address-in answer wrong");
endmodule

// *** drm_defines.svh ***
// constants for the disc/drum controller instruction interface
// assumes inclusion by the package and the controller module only
`ifndef DRM_DEFINES_SVH
`define DRM_DEFINES_SVH
`define DRM_MB_INH   2
`define DRM_MB_WR    1
`define DRM_MB_RD    0
`define DRM_MODE_X1  3'h3
`define DRM_MODE_X2  3'h7
`define DRM_MODE_AW  3'h2
`define DRM_ST_BUSY  7
`define DRM_ST_NRDY  6
`define DRM_ST_PERR  5
`define DRM_ST_WLOCK 4
`define DRM_ST_TERM  2
`define DRM_ST_SYNC  1
`define DRM_ST_ILL   0
`define DRM_SEC_SMALL 7'h3F
`define DRM_SEC_LARGE 7'h7F
`define DRM_ZERO16   16'h0000
`endif

// *** drm_pkg.sv ***
// types shared by the disc/drum controller
// assumes the defines header is on the include path
package drm_pkg;
  `include "drm_defines.svh"
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] acc;
  } drm_instr_t;
  typedef struct packed {
    logic co;
    logic dout;
    logic di;
    logic si;
    logic ai;
  } drm_strb_t;
  typedef enum logic [1:0] {DRM_IDLE, DRM_SEEK, DRM_XFER} drm_state_t;
endpackage

// *** drm_cpu_model.sv ***
// cpu channel model: issues one instruction, takes the answer
// assumes the controller registers its answer one cycle after a strobe
`timescale 1ns/10ps
module drm_cpu_model (
  input  wire logic                clk,
  input  wire logic                ack,
  input  wire logic [15:0]         data,
  output drm_pkg::drm_instr_t      instr,
  output drm_pkg::drm_strb_t       strb
);
  import drm_pkg::*;
  logic        got_ack;
  logic [15:0] got_data;
  initial
  begin
    instr = '0;
    strb = '0;
  end
  // strobe for one edge, answer taken the next cycle
  task automatic issue(input logic [4:0] k, input logic [7:0] a,
                       input logic [15:0] d);
    @(posedge clk);
    #1;
    instr = {a, d};
    strb = k;
    @(posedge clk);
    #1;
    got_ack = ack;
    got_data = data;
    strb = '0;
    instr = {~a, ~d};
  endtask
endmodule

// *** drm_ctrl_tb.sv ***
// testbench: cpu model and drive stimulus around the controller
// assumes package, controller and cpu model are compiled first
`timescale 1ns/10ps
module drm_ctrl_tb;
  import drm_pkg::*;
  localparam logic [4:0] DA   = 5'h10;
  localparam logic [4:0] K_CO = 5'h10;
  localparam logic [4:0] K_DO = 5'h08;
  localparam logic [4:0] K_DI = 5'h04;
  localparam logic [4:0] K_SI = 5'h02;
  localparam logic [4:0] K_AI = 5'h01;
  logic        clk;
  logic        rst_n;
  logic        prio_in;
  logic        heads_on;
  logic        drv_on_sector;
  logic        drv_tick;
  logic [16:0] drv_rd_word;
  logic        ack_ff;
  logic        svc_ff;
  logic        drv_start_ff;
  logic        drv_unit_ff;
  logic        drv_wr_en_ff;
  logic [15:0] data_ff;
  logic [14:0] drv_sector_ff;
  logic [6:0]  drv_word_ff;
  logic [16:0] drv_wr_ff;
  logic        wr_seen;
  logic        dev_ready;
  logic        large_sec;
  logic        wr_locked;
  logic        sync_lost;
  drm_instr_t  instr;
  drm_strb_t   strb;
  int          miscompares;
  int          cmp_count;
  int          cycles;
  drm_ctrl #(.DEV_ADDR(DA), .MAX_SECTOR(15'h0FFF)) i_dut (
    .clk          (clk),
    .rst_n        (rst_n),
    .instr        (instr),
    .strb         (strb),
    .prio_in      (prio_in),
    .heads_on     (heads_on),
    .dev_ready    (dev_ready),
    .large_sec    (large_sec),
    .wr_locked    (wr_locked),
    .sync_lost    (sync_lost),
    .drv_on_sector(drv_on_sector),
    .drv_tick     (drv_tick),
    .drv_rd_word  (drv_rd_word),
    .ack_ff       (ack_ff),
    .svc_ff       (svc_ff),
    .data_ff      (data_ff),
    .drv_start_ff (drv_start_ff),
    .drv_unit_ff  (drv_unit_ff),
    .drv_sector_ff(drv_sector_ff),
    .drv_word_ff  (drv_word_ff),
    .drv_wr_ff    (drv_wr_ff),
    .drv_wr_en_ff (drv_wr_en_ff)
  );
  drm_cpu_model i_cpu (
    .clk  (clk),
    .ack  (ack_ff),
    .data (data_ff),
    .instr(instr),
    .strb (strb)
  );
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t flag %b want %b", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [16:0] g, input logic [16:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t word %h want %h", $time, g, e);
    end
  endtask
  task automatic op(input logic [4:0] k, input logic [7:0] a,
                    input logic [15:0] d, input logic ea,
                    input logic [15:0] ed);
    i_cpu.issue(k, a, d);
    chk_bit(i_cpu.got_ack, ea);
    chk_word({1'b0, i_cpu.got_data}, {1'b0, ed});
  endtask
  task automatic skip(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic seek();
    skip(1);
    drv_on_sector = 1'b1;
    skip(1);
    drv_on_sector = 1'b0;
  endtask
  task automatic tick(input logic [16:0] w);
    skip(1);
    drv_rd_word = w;
    drv_tick = 1'b1;
    skip(1);
    wr_seen = drv_wr_en_ff;
    drv_tick = 1'b0;
    drv_rd_word = ~w;
  endtask
  task automatic t_reset();
    chk_bit(svc_ff, 1'b0);
    chk_bit(drv_start_ff, 1'b0);
    op(K_SI, {DA, 3'h5}, 16'h0000, 1'b0, 16'h0000);
  endtask
  task automatic t_refuse();
    heads_on = 1'b0;
    op(K_CO, {DA, 3'h2}, 16'h0000, 1'b0, 16'h0000);
    heads_on = 1'b1;
    op(K_CO, {DA, 3'h3}, 16'h0000, 1'b0, 16'h0000);
    op(K_CO, {DA, 3'h7}, 16'h0000, 1'b0, 16'h0000);
    op(K_CO, {~DA, 3'h4}, 16'h0000, 1'b0, 16'h0000);
    op(K_CO, {DA, 3'h4}, 16'h0000, 1'b1, 16'h0000);
    op(K_DO, {DA, 3'h0}, 16'h5555, 1'b0, 16'h0000);
    op(K_DI, {DA, 3'h0}, 16'h0000, 1'b0, 16'h0000);
    chk_bit(svc_ff, 1'b0);
  endtask
  task automatic t_write();
    op(K_CO, {DA, 3'h6}, 16'h0000, 1'b1, 16'h0000);
    skip(2);
    chk_bit(svc_ff, 1'b0);
    seek();
    tick(17'h00000);
    op(K_CO, {DA, 3'h2}, 16'h8005, 1'b1, 16'h0000);
    chk_bit(drv_start_ff, 1'b1);
    chk_bit(drv_unit_ff, 1'b1);
    chk_word({2'b00, drv_sector_ff}, 17'h00005);
    skip(1);
    chk_bit(svc_ff, 1'b1);
    op(K_CO, {DA, 3'h5}, 16'h0000, 1'b0, 16'h0000);
    op(K_CO, {DA, 3'h0}, 16'h0000, 1'b1, 16'h0000);
    chk_bit(svc_ff, 1'b0);
    op(K_DO, {DA, 3'h7}, 16'h1233, 1'b1, 16'h0000);
    chk_bit(svc_ff, 1'b0);
    seek();
    tick(17'h00000);
    chk_bit(wr_seen, 1'b1);
    chk_word(drv_wr_ff, {~^16'h1233, 16'h1233});
    chk_word({10'h000, drv_word_ff}, 17'h00001);
    skip(3);
    chk_bit(svc_ff, 1'b1);
    tick(17'h00000);
    chk_bit(svc_ff, 1'b1);
    op(K_SI, {DA, 3'h1}, 16'h0000, 1'b0, 16'h0004);
    chk_bit(svc_ff, 1'b0);
  endtask
  task automatic t_read();
    op(K_CO, {DA, 3'h1}, 16'h0003, 1'b1, 16'h0000);
    chk_bit(svc_ff, 1'b0);
    seek();
    tick({~^16'hA5C3, 16'hA5C3});
    skip(2);
    chk_bit(svc_ff, 1'b1);
    op(K_DI, {DA, 3'h6}, 16'h0000, 1'b1, 16'hA5C3);
    chk_bit(svc_ff, 1'b0);
    tick({~^16'h3C00, 16'h3C00});
    skip(2);
    prio_in = 1'b0;
    op(K_AI, 8'hFF, 16'h0000, 1'b0, 16'h0000);
    chk_bit(svc_ff, 1'b1);
    prio_in = 1'b1;
    op(K_AI, 8'h00, 16'h0000, 1'b0, {8'h00, DA, 3'h0});
    chk_bit(svc_ff, 1'b0);
    op(K_DI, {DA, 3'h0}, 16'h0000, 1'b1, 16'h3C00);
    tick({^16'h00F1, 16'h00F1});
    op(K_SI, {DA, 3'h0}, 16'h0000, 1'b0, 16'h0024);
  endtask
  task automatic sec_run(input logic big, input logic [16:0] ew,
                         input logic [16:0] es);
    large_sec = big;
    op(K_CO, {DA, 3'h5}, 16'h0007, 1'b1, 16'h0000);
    seek();
    repeat (64)
    begin
      tick({1'b1, 16'h0000});
      op(K_DI, {DA, 3'h0}, 16'h0000, 1'b1, 16'h0000);
    end
    chk_word({10'h000, drv_word_ff}, ew);
    chk_word({2'b00, drv_sector_ff}, es);
    tick({1'b1, 16'h0000});
    tick({1'b1, 16'h0000});
    op(K_SI, {DA, 3'h0}, 16'h0000, 1'b0, 16'h0004);
  endtask
  task automatic t_status();
    dev_ready = 1'b0;
    wr_locked = 1'b1;
    op(K_CO, {DA, 3'h6}, 16'h0000, 1'b1, 16'h0000);
    chk_bit(drv_start_ff, 1'b0);
    op(K_SI, {DA, 3'h7}, 16'h0000, 1'b0, 16'h0050);
    dev_ready = 1'b1;
    wr_locked = 1'b0;
    op(K_CO, {DA, 3'h5}, 16'h0000, 1'b1, 16'h0000);
    sync_lost = 1'b1;
    skip(1);
    sync_lost = 1'b0;
    op(K_SI, {DA, 3'h0}, 16'h0000, 1'b0, 16'h0002);
    op(K_CO, {DA, 3'h5}, 16'h1000, 1'b1, 16'h0000);
    op(K_SI, {DA, 3'h0}, 16'h0000, 1'b0, 16'h0001);
  endtask
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    prio_in = 1'b0;
    heads_on = 1'b1;
    drv_on_sector = 1'b0;
    drv_tick = 1'b0;
    drv_rd_word = 17'h00000;
    wr_seen = 1'b0;
    dev_ready = 1'b1;
    large_sec = 1'b0;
    wr_locked = 1'b0;
    sync_lost = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_refuse();
    t_write();
    t_read();
    sec_run(1'b1, 17'h00040, 17'h00007);
    sec_run(1'b0, 17'h00000, 17'h00008);
    t_status();
    print_verdict();
  end
endmodule
